// ==== src/bmsd_decoder.sv ====
// bitmap state command decoder, per-handle state store and texel unpacker
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module bmsd_decoder (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	// display-list command stream
	input  wire logic        cmd_valid_i,
	input  wire logic [31:0] cmd_word_i,
	input  wire logic [4:0]  cmd_handle_i,
	// palette memory port
	input  wire logic [7:0]  pal_addr_i,
	input  wire logic [31:0] pal_wdata_i,
	input  wire logic        pal_wr_i,
	input  wire logic        pal_rd_i,
	output logic      [31:0] pal_rdata_o,
	// texel request from rasterizer
	input  wire logic        fetch_req_i,
	input  wire logic [4:0]  fetch_handle_i,
	input  wire logic [8:0]  fetch_x_i,
	input  wire logic [8:0]  fetch_y_i,
	output logic             fetch_ready_o,
	// graphics memory read
	output logic      [19:0] mem_addr_o,
	output logic             mem_rd_o,
	input  wire logic        mem_valid_i,
	input  wire logic [15:0] mem_data_i,
	// texel result
	output logic      [31:0] pix_argb_o,
	output logic             pix_valid_o,
	output logic             pix_bilinear_o,
	output logic      [8:0]  pix_width_o,
	output logic      [8:0]  pix_height_o,
	// glyph result for character grids
	output logic             glyph_valid_o,
	output logic      [7:0]  glyph_code_o,
	output logic      [4:0]  glyph_handle_o,
	output logic      [2:0]  glyph_row_o,
	output logic      [2:0]  glyph_col_o,
	output logic      [3:0]  glyph_fg_o,
	output logic      [2:0]  glyph_bg_o,
	output logic             glyph_cursor_o
);
	typedef enum logic [2:0] {
		S_IDLE,
		S_LOOKUP,
		S_WAIT,
		S_PALREQ,
		S_PALWAIT
	} bmsd_fsm_type;

	typedef struct packed {
		bmsd_fsm_type                      fsm;
		logic [bmsd_pkg::COORD_W-1:0]      fx;
		logic [bmsd_pkg::COORD_W-1:0]      fy;
		logic [bmsd_pkg::FMT_W-1:0]        fmt;
		logic [bmsd_pkg::ADDR_W-1:0]       mem_addr;
		logic                              mem_rd;
		logic [bmsd_pkg::PAL_AW-1:0]       idx;
		logic [bmsd_pkg::PIX_W-1:0]        pix;
		logic                              pix_valid;
		logic                              bilinear;
		logic [bmsd_pkg::HGT_W-1:0]        dwidth;
		logic [bmsd_pkg::HGT_W-1:0]        dheight;
		logic                              glyph_valid;
		logic [7:0]                        glyph_code;
		logic [4:0]                        glyph_handle;
		logic [bmsd_pkg::CELL_SHIFT-1:0]   glyph_row;
		logic [bmsd_pkg::CELL_SHIFT-1:0]   glyph_col;
		logic [3:0]                        fg;
		logic [2:0]                        bg;
		logic                              cursor;
	} bmsd_core_type;

	bmsd_core_type                  core_ff;
	bmsd_core_type                  nxt_core;

	// decoded command fields
	logic [7:0]                     cmd_op;
	logic                           wr_layout;
	logic                           wr_size;
	logic                           wr_source;
	logic                           fetch_take;
	// per-handle state as read back
	logic [bmsd_pkg::LAY_W-1:0]     lay_q;
	logic [bmsd_pkg::SIZ_W-1:0]     siz_q;
	logic [bmsd_pkg::ADDR_W-1:0]    src_q;
	// palette read port
	logic                           pal_re;
	logic [bmsd_pkg::PAL_AW-1:0]    pal_raddr;
	logic [bmsd_pkg::PIX_W-1:0]     pal_q;

	// command decode from the top byte; parameters from the low bits
	assign cmd_op    = cmd_word_i[bmsd_pkg::OP_HI:bmsd_pkg::OP_LO];
	assign wr_layout = cmd_valid_i && (cmd_op == bmsd_pkg::OP_LAYOUT);
	assign wr_size   = cmd_valid_i && (cmd_op == bmsd_pkg::OP_SIZE);
	assign wr_source = cmd_valid_i && (cmd_op == bmsd_pkg::OP_SOURCE);

	// separate stores per command so each write touches only its own fields
	bmsd_store #(.WIDTH(bmsd_pkg::LAY_W), .AW(bmsd_pkg::HANDLE_W)) u_layout (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.wr_i      (wr_layout),
		.waddr_i   (cmd_handle_i),
		.wdata_i   ({cmd_word_i[bmsd_pkg::LAY_FMT_HI:bmsd_pkg::LAY_FMT_LO],
		             cmd_word_i[bmsd_pkg::LAY_PITCH_HI:bmsd_pkg::LAY_PITCH_LO],
		             cmd_word_i[bmsd_pkg::LAY_HGT_HI:bmsd_pkg::LAY_HGT_LO]}),
		.rd_i      (fetch_take),
		.raddr_i   (fetch_handle_i),
		.rdata_o   (lay_q)
	);

	bmsd_store #(.WIDTH(bmsd_pkg::SIZ_W), .AW(bmsd_pkg::HANDLE_W)) u_size (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.wr_i      (wr_size),
		.waddr_i   (cmd_handle_i),
		.wdata_i   ({cmd_word_i[bmsd_pkg::SIZ_FILTER_BIT],
		             cmd_word_i[bmsd_pkg::SIZ_WRAPX_BIT],
		             cmd_word_i[bmsd_pkg::SIZ_WRAPY_BIT],
		             cmd_word_i[bmsd_pkg::SIZ_WID_HI:bmsd_pkg::SIZ_WID_LO],
		             cmd_word_i[bmsd_pkg::SIZ_HGT_HI:bmsd_pkg::SIZ_HGT_LO]}),
		.rd_i      (fetch_take),
		.raddr_i   (fetch_handle_i),
		.rdata_o   (siz_q)
	);

	// reserved bits 23:20 are dropped, never stored
	bmsd_store #(.WIDTH(bmsd_pkg::ADDR_W), .AW(bmsd_pkg::HANDLE_W)) u_source (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.wr_i      (wr_source),
		.waddr_i   (cmd_handle_i),
		.wdata_i   (cmd_word_i[bmsd_pkg::SRC_HI:bmsd_pkg::SRC_LO]),
		.rd_i      (fetch_take),
		.raddr_i   (fetch_handle_i),
		.rdata_o   (src_q)
	);

	// software read wins the palette port; the fetch retries next cycle
	assign pal_re    = pal_rd_i || (core_ff.fsm == S_PALREQ);
	assign pal_raddr = pal_rd_i ? pal_addr_i : core_ff.idx;

	bmsd_store #(.WIDTH(bmsd_pkg::PIX_W), .AW(bmsd_pkg::PAL_AW)) u_palette (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.wr_i      (pal_wr_i),
		.waddr_i   (pal_addr_i),
		.wdata_i   (pal_wdata_i),
		.rd_i      (pal_re),
		.raddr_i   (pal_raddr),
		.rdata_o   (pal_q)
	);

	assign fetch_ready_o = (core_ff.fsm == S_IDLE);
	assign fetch_take    = fetch_req_i && fetch_ready_o;
	assign pal_rdata_o   = pal_q;

	// channel widening by bit replication keeps full scale at 8'hff
	function automatic logic [7:0] widen1(input logic v);
		widen1 = {8{v}};
	endfunction
	function automatic logic [7:0] widen2(input logic [1:0] v);
		widen2 = {v, v, v, v};
	endfunction
	function automatic logic [7:0] widen3(input logic [2:0] v);
		widen3 = {v, v, v[2:1]};
	endfunction
	function automatic logic [7:0] widen4(input logic [3:0] v);
		widen4 = {v, v};
	endfunction
	function automatic logic [7:0] widen5(input logic [4:0] v);
		widen5 = {v, v[4:2]};
	endfunction
	function automatic logic [7:0] widen6(input logic [5:0] v);
		widen6 = {v, v[5:4]};
	endfunction

	// address generation and unpacking
	always_comb
	begin
		logic [bmsd_pkg::FMT_W-1:0]     fmt;
		logic [bmsd_pkg::PITCH_W-1:0]   pitch;
		logic [bmsd_pkg::HGT_W-1:0]     rows;
		logic                           wrapx;
		logic                           wrapy;
		logic [bmsd_pkg::PITCH_W-1:0]   boff;
		logic [bmsd_pkg::HGT_W-1:0]     row;
		logic                           outside;
		logic [18:0]                    row_base;
		logic [7:0]                     b;
		logic [3:0]                     nib;
		logic [7:0]                     lum;
		logic [bmsd_pkg::CELL_SHIFT-1:0] sub;
		fmt      = lay_q[bmsd_pkg::LAY_W-1 -: bmsd_pkg::FMT_W];
		pitch    = lay_q[bmsd_pkg::HGT_W +: bmsd_pkg::PITCH_W];
		rows     = lay_q[bmsd_pkg::HGT_W-1:0];
		wrapx    = siz_q[bmsd_pkg::SIZ_W-2];
		wrapy    = siz_q[bmsd_pkg::SIZ_W-3];
		boff     = '0;
		row      = '0;
		outside  = 1'b0;
		row_base = '0;
		b        = mem_data_i[bmsd_pkg::BYTE_HI:0];
		nib      = '0;
		lum      = '0;
		sub      = core_ff.fx[bmsd_pkg::CELL_SHIFT-1:0];
		nxt_core = core_ff;
		nxt_core.mem_rd      = 1'b0;
		nxt_core.pix_valid   = 1'b0;
		nxt_core.glyph_valid = 1'b0;
		case (core_ff.fsm)
			S_IDLE:
			begin
				if (fetch_take)
				begin
					nxt_core.fx  = fetch_x_i;
					nxt_core.fy  = fetch_y_i;
					nxt_core.fsm = S_LOOKUP;
				end
			end
			S_LOOKUP:
			begin
				// byte offset in the row and row index per format
				row = core_ff.fy;
				case (fmt)
					bmsd_pkg::FMT_MONO_1BPP:
						boff = 10'({1'b0, core_ff.fx} >> bmsd_pkg::CELL_SHIFT);
					bmsd_pkg::FMT_GRAY_4BPP:
						boff = 10'({1'b0, core_ff.fx} >> 1);
					bmsd_pkg::FMT_ARGB1555, bmsd_pkg::FMT_ARGB4444, bmsd_pkg::FMT_RGB565:
						boff = {core_ff.fx, 1'b0};
					bmsd_pkg::FMT_COLUMN_PLOT:
					begin
						boff = {1'b0, core_ff.fx};
						row  = '0;
					end
					bmsd_pkg::FMT_CHAR_GRID_PLAIN:
					begin
						boff = 10'({1'b0, core_ff.fx} >> bmsd_pkg::CELL_SHIFT);
						row  = core_ff.fy >> bmsd_pkg::CELL_SHIFT;
					end
					bmsd_pkg::FMT_CHAR_GRID_ATTR:
					begin
						boff = 10'({1'b0, core_ff.fx} >> (bmsd_pkg::CELL_SHIFT - 1)) & ~10'h001;
						row  = core_ff.fy >> bmsd_pkg::CELL_SHIFT;
					end
					default:
						boff = {1'b0, core_ff.fx};
				endcase
				// repeat masks with the power-of-two dimension, border rejects
				if (wrapx == bmsd_pkg::WRAP_REPEAT)
					boff = boff & (pitch - 10'h001);
				else if (boff >= pitch)
					outside = 1'b1;
				if (wrapy == bmsd_pkg::WRAP_REPEAT)
					row = row & (rows - 9'h001);
				else if (row >= rows)
					outside = 1'b1;
				if (fmt > bmsd_pkg::FMT_LAST)
					outside = 1'b1;
				row_base = row * pitch;
				nxt_core.mem_addr = src_q + 20'(row_base) + 20'(boff);
				nxt_core.fmt      = fmt;
				nxt_core.bilinear = siz_q[bmsd_pkg::SIZ_W-1] == bmsd_pkg::FILTER_BILINEAR;
				nxt_core.dwidth   = siz_q[bmsd_pkg::HGT_W +: bmsd_pkg::HGT_W];
				nxt_core.dheight  = siz_q[bmsd_pkg::HGT_W-1:0];
				if (outside)
				begin
					nxt_core.pix       = bmsd_pkg::PIX_CLEAR;
					nxt_core.pix_valid = 1'b1;
					nxt_core.fsm       = S_IDLE;
				end
				else
				begin
					nxt_core.mem_rd = 1'b1;
					nxt_core.fsm    = S_WAIT;
				end
			end
			S_WAIT:
			begin
				if (mem_valid_i)
				begin
					nxt_core.pix_valid = 1'b1;
					nxt_core.fsm       = S_IDLE;
					nib = sub[0] ? b[bmsd_pkg::NIBL_HI:bmsd_pkg::NIBL_LO] : b[bmsd_pkg::NIB_HI:bmsd_pkg::NIB_LO];
					case (core_ff.fmt)
						bmsd_pkg::FMT_MONO_1BPP:
							lum = widen1(b[bmsd_pkg::BYTE_HI - sub]);
						bmsd_pkg::FMT_GRAY_4BPP:
							lum = widen4(nib);
						default:
							lum = b;
					endcase
					case (core_ff.fmt)
						bmsd_pkg::FMT_MONO_1BPP, bmsd_pkg::FMT_GRAY_4BPP, bmsd_pkg::FMT_GRAY_8BPP:
							nxt_core.pix = {bmsd_pkg::ALPHA_FULL, lum, lum, lum};
						bmsd_pkg::FMT_ARGB_2BIT_EACH:
							nxt_core.pix = {widen2(b[bmsd_pkg::A2_HI:bmsd_pkg::A2_LO]),
							                widen2(b[bmsd_pkg::R2_HI:bmsd_pkg::R2_LO]),
							                widen2(b[bmsd_pkg::G2_HI:bmsd_pkg::G2_LO]),
							                widen2(b[bmsd_pkg::B2_HI:bmsd_pkg::B2_LO])};
						bmsd_pkg::FMT_ARGB1555:
							nxt_core.pix = {widen1(mem_data_i[bmsd_pkg::A15_BIT]),
							                widen5(mem_data_i[bmsd_pkg::R15_HI:bmsd_pkg::R15_LO]),
							                widen5(mem_data_i[bmsd_pkg::G15_HI:bmsd_pkg::G15_LO]),
							                widen5(mem_data_i[bmsd_pkg::B15_HI:bmsd_pkg::B15_LO])};
						bmsd_pkg::FMT_ARGB4444:
							nxt_core.pix = {widen4(mem_data_i[bmsd_pkg::A4_HI:bmsd_pkg::A4_LO]),
							                widen4(mem_data_i[bmsd_pkg::R4_HI:bmsd_pkg::R4_LO]),
							                widen4(mem_data_i[bmsd_pkg::G4_HI:bmsd_pkg::G4_LO]),
							                widen4(mem_data_i[bmsd_pkg::B4_HI:bmsd_pkg::B4_LO])};
						bmsd_pkg::FMT_RGB332:
							nxt_core.pix = {bmsd_pkg::ALPHA_FULL,
							                widen3(b[bmsd_pkg::R3_HI:bmsd_pkg::R3_LO]),
							                widen3(b[bmsd_pkg::G3_HI:bmsd_pkg::G3_LO]),
							                widen2(b[bmsd_pkg::B3_HI:bmsd_pkg::B3_LO])};
						bmsd_pkg::FMT_RGB565:
							nxt_core.pix = {bmsd_pkg::ALPHA_FULL,
							                widen5(mem_data_i[bmsd_pkg::R6_HI:bmsd_pkg::R6_LO]),
							                widen6(mem_data_i[bmsd_pkg::G6_HI:bmsd_pkg::G6_LO]),
							                widen5(mem_data_i[bmsd_pkg::B6_HI:bmsd_pkg::B6_LO])};
						bmsd_pkg::FMT_INDEXED_COLOR:
						begin
							// colour comes from the palette, so hold the pixel back
							nxt_core.idx       = b;
							nxt_core.pix_valid = 1'b0;
							nxt_core.fsm       = S_PALREQ;
						end
						bmsd_pkg::FMT_COLUMN_PLOT:
							nxt_core.pix = ({1'b0, b} < core_ff.fy) ? bmsd_pkg::PIX_OPAQUE : bmsd_pkg::PIX_CLEAR;
						bmsd_pkg::FMT_CHAR_GRID_PLAIN, bmsd_pkg::FMT_CHAR_GRID_ATTR:
						begin
							// glyph raster is drawn downstream from the font handle
							nxt_core.pix          = bmsd_pkg::PIX_CLEAR;
							nxt_core.pix_valid    = 1'b0;
							nxt_core.glyph_valid  = 1'b1;
							nxt_core.glyph_code   = b;
							nxt_core.glyph_handle = b[bmsd_pkg::BYTE_HI] ? bmsd_pkg::GLYPH_HANDLE_HI
							                                               : bmsd_pkg::GLYPH_HANDLE_LO;
							nxt_core.glyph_row    = core_ff.fy[bmsd_pkg::CELL_SHIFT-1:0];
							nxt_core.glyph_col    = sub;
							if (core_ff.fmt == bmsd_pkg::FMT_CHAR_GRID_ATTR)
							begin
								nxt_core.fg     = mem_data_i[bmsd_pkg::ATTR_FG_HI:bmsd_pkg::ATTR_FG_LO];
								nxt_core.bg     = mem_data_i[bmsd_pkg::ATTR_BG_HI:bmsd_pkg::ATTR_BG_LO];
								nxt_core.cursor = mem_data_i[bmsd_pkg::ATTR_CUR_BIT];
							end
							else
							begin
								nxt_core.fg     = '0;
								nxt_core.bg     = '0;
								nxt_core.cursor = 1'b0;
							end
						end
						default:
							nxt_core.pix = bmsd_pkg::PIX_CLEAR;
					endcase
				end
			end
			S_PALREQ:
			begin
				if (!pal_rd_i)
					nxt_core.fsm = S_PALWAIT;
			end
			S_PALWAIT:
			begin
				// entry holds alpha low and blue high; reorder to argb
				nxt_core.pix = {pal_q[bmsd_pkg::PA_HI:bmsd_pkg::PA_LO], pal_q[bmsd_pkg::PR_HI:bmsd_pkg::PR_LO],
				                pal_q[bmsd_pkg::PG_HI:bmsd_pkg::PG_LO], pal_q[bmsd_pkg::PB_HI:bmsd_pkg::PB_LO]};
				nxt_core.pix_valid = 1'b1;
				nxt_core.fsm       = S_IDLE;
			end
			default:
				nxt_core.fsm = S_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			core_ff <= '0;
		else
			core_ff <= nxt_core;
	end

	// outputs straight from the state register
	assign mem_addr_o     = core_ff.mem_addr;
	assign mem_rd_o       = core_ff.mem_rd;
	assign pix_argb_o     = core_ff.pix;
	assign pix_valid_o    = core_ff.pix_valid;
	assign pix_bilinear_o = core_ff.bilinear;
	assign pix_width_o    = core_ff.dwidth;
	assign pix_height_o   = core_ff.dheight;
	assign glyph_valid_o  = core_ff.glyph_valid;
	assign glyph_code_o   = core_ff.glyph_code;
	assign glyph_handle_o = core_ff.glyph_handle;
	assign glyph_row_o    = core_ff.glyph_row;
	assign glyph_col_o    = core_ff.glyph_col;
	assign glyph_fg_o     = core_ff.fg;
	assign glyph_bg_o     = core_ff.bg;
	assign glyph_cursor_o = core_ff.cursor;
endmodule
`default_nettype wire

// ==== src/bmsd_pkg.sv ====
// constants, field layouts and format codes of the bitmap state decoder
// How it works
// - opcode 07 is layout: format, row pitch ending at bit 9, height in low nine
// - format codes 0 to 11 are valid; any other code draws a transparent pixel
// - row pitch is bytes between stored rows, height is rows stored in memory
// - luminance pixels unpack from the byte msb downward, 8/2/1 pixels per byte
// - 2-bit-each is a7:6 r5:4 g3:2 b1:0; 1555 is a15 r14:10 g9:5 b4:0
// - 4444 has 4-bit fields from 15:12 down; 332 r7:5 g4:2 b1:0; 565 r15:11 g10:5 b4:0
// - indexed colour: each byte picks one of 256 32-bit palette memory entries
// - column plot: byte at x, opaque when below y, else transparent, 256x256 max
// - plain char grid: each byte picks an 8x8 glyph from font handles 16/17
// - attributed char grid: element carries glyph, background, foreground and cursor bits
// - opcode 08 sizes: filter 20, wrap x 19, wrap y 18, width, height
// - filter 0 is point sampling, 1 is bilinear interpolation
// - wrap 0 is border, 1 repeats; x and y decide independently
// - drawn width and height are the on-screen extent, independent of memory size
// - opcode 01 is the source command: bits 23:20 reserved, address in 19:0
// - the three commands update the currently selected handle, 0 to 31
// - the top byte picks the command, the low bits carry its parameters
package bmsd_pkg;
	// command word
	localparam int          CMD_W = 32;
	localparam int          OP_HI = 31, OP_LO = 24;
	localparam logic [7:0]  OP_LAYOUT = 8'h07, OP_SIZE = 8'h08, OP_SOURCE = 8'h01;
	localparam int          LAY_FMT_HI = 23, LAY_FMT_LO = 19;
	localparam int          LAY_PITCH_HI = 18, LAY_PITCH_LO = 9;
	localparam int          LAY_HGT_HI = 8, LAY_HGT_LO = 0;
	localparam int          SIZ_FILTER_BIT = 20, SIZ_WRAPX_BIT = 19, SIZ_WRAPY_BIT = 18;
	localparam int          SIZ_WID_HI = 17, SIZ_WID_LO = 9;
	localparam int          SIZ_HGT_HI = 8, SIZ_HGT_LO = 0;
	localparam int          SRC_HI = 19, SRC_LO = 0;

	// widths
	localparam int          FMT_W = 5, PITCH_W = 10, HGT_W = 9, ADDR_W = 20;
	localparam int          HANDLE_W = 5, COORD_W = 9, PAL_AW = 8, PIX_W = 32;
	localparam int          LAY_W = FMT_W + PITCH_W + HGT_W;
	localparam int          SIZ_W = 3 + 2 * HGT_W;

	// pixel format codes
	localparam logic [4:0]  FMT_ARGB1555 = 5'h00, FMT_MONO_1BPP = 5'h01, FMT_GRAY_4BPP = 5'h02;
	localparam logic [4:0]  FMT_GRAY_8BPP = 5'h03, FMT_RGB332 = 5'h04, FMT_ARGB_2BIT_EACH = 5'h05;
	localparam logic [4:0]  FMT_ARGB4444 = 5'h06, FMT_RGB565 = 5'h07, FMT_INDEXED_COLOR = 5'h08;
	localparam logic [4:0]  FMT_CHAR_GRID_PLAIN = 5'h09, FMT_CHAR_GRID_ATTR = 5'h0a;
	localparam logic [4:0]  FMT_COLUMN_PLOT = 5'h0b, FMT_LAST = 5'h0b;

	// mode values
	localparam logic        FILTER_POINT_SAMPLE = 1'b0, FILTER_BILINEAR = 1'b1;
	localparam logic        WRAP_BORDER = 1'b0, WRAP_REPEAT = 1'b1;

	// pixel field layouts in the fetched little-endian halfword
	localparam int          A2_HI = 7, A2_LO = 6, R2_HI = 5, R2_LO = 4, G2_HI = 3, G2_LO = 2, B2_HI = 1, B2_LO = 0;
	localparam int          A15_BIT = 15, R15_HI = 14, R15_LO = 10, G15_HI = 9, G15_LO = 5, B15_HI = 4, B15_LO = 0;
	localparam int          A4_HI = 15, A4_LO = 12, R4_HI = 11, R4_LO = 8, G4_HI = 7, G4_LO = 4, B4_HI = 3, B4_LO = 0;
	localparam int          R3_HI = 7, R3_LO = 5, G3_HI = 4, G3_LO = 2, B3_HI = 1, B3_LO = 0;
	localparam int          R6_HI = 15, R6_LO = 11, G6_HI = 10, G6_LO = 5, B6_HI = 4, B6_LO = 0;
	localparam int          BYTE_HI = 7, NIB_HI = 7, NIB_LO = 4, NIBL_HI = 3, NIBL_LO = 0;

	// palette entry layout
	localparam int          PA_HI = 7, PA_LO = 0, PR_HI = 15, PR_LO = 8;
	localparam int          PG_HI = 23, PG_LO = 16, PB_HI = 31, PB_LO = 24;

	// character grids: 8x8 cells, glyph font handles
	localparam int          CELL_SHIFT = 3;
	localparam logic [4:0]  GLYPH_HANDLE_LO = 5'h10, GLYPH_HANDLE_HI = 5'h11;
	localparam int          ATTR_FG_HI = 11, ATTR_FG_LO = 8, ATTR_BG_HI = 14, ATTR_BG_LO = 12, ATTR_CUR_BIT = 15;

	// opaque and transparent output values
	localparam logic [31:0] PIX_CLEAR = 32'h0000_0000, PIX_OPAQUE = 32'hffff_ffff;
	localparam logic [7:0]  ALPHA_FULL = 8'hff;
endpackage

// ==== src/bmsd_store.sv ====
// simple dual-port memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module bmsd_store #(
	parameter int WIDTH = 32,
	parameter int AW    = 5
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	// write port
	input  wire logic             wr_i,
	input  wire logic [AW-1:0]    waddr_i,
	input  wire logic [WIDTH-1:0] wdata_i,
	// read port
	input  wire logic             rd_i,
	input  wire logic [AW-1:0]    raddr_i,
	output logic      [WIDTH-1:0] rdata_o
);
	typedef struct packed {
		logic [WIDTH-1:0] rdata;
	} bmsd_store_type;

	bmsd_store_type   st_ff;
	bmsd_store_type   nxt_st;
	logic [WIDTH-1:0] mem_ff [2**AW];

	// array has no reset so it maps onto ram cells
	always_ff @(posedge clk_i)
	begin
		if (wr_i)
			mem_ff[waddr_i] <= wdata_i;
	end

	// read during write to the same entry returns the old word
	always_comb
	begin
		nxt_st = st_ff;
		if (rd_i)
			nxt_st.rdata = mem_ff[raddr_i];
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign rdata_o = st_ff.rdata;
endmodule
`default_nettype wire

// ==== verif/bmsd_mem_model.sv ====
// graphics memory model answering byte-pair reads promptly or slowly
`timescale 1ns/1ps
`default_nettype none
module bmsd_mem_model (
	// clock and pace
	input  wire logic        clk_i,
	input  wire logic        slow_i,
	// read request from the decoder
	input  wire logic        rd_i,
	input  wire logic [19:0] addr_i,
	// read answer
	output logic             valid_o,
	output logic      [15:0] data_o
);
	logic [1:0]  cnt = 2'h0;
	logic [19:0] a;
	initial data_o = 16'h0000;
	// byte at a is a[7:0]^a5; data flips when not valid so stale bytes never match
	always @(posedge clk_i)
	begin
		valid_o <= 1'b0;
		data_o  <= ~data_o;
		if (rd_i)
		begin
			a   <= addr_i;
			cnt <= slow_i ? 2'h3 : 2'h1;
		end
		else if (cnt != 2'h0)
		begin
			cnt <= cnt - 2'h1;
			if (cnt == 2'h1)
			begin
				valid_o <= 1'b1;
				data_o  <= {(a[7:0] + 8'h01) ^ 8'ha5, a[7:0] ^ 8'ha5};
			end
		end
	end
endmodule
`default_nettype wire

// ==== verif/bmsd_decoder_asserts.sv ====
// checker of the texel fetch handshake and glyph results
`timescale 1ns/1ps
`default_nettype none
module bmsd_decoder_asserts (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	// fetch handshake and results
	input  wire logic        fetch_req_i,
	input  wire logic        fetch_ready_o,
	input  wire logic        mem_rd_o,
	input  wire logic [19:0] mem_addr_o,
	input  wire logic        pix_valid_o,
	input  wire logic        glyph_valid_o,
	input  wire logic [4:0]  glyph_handle_o,
	input  wire logic [7:0]  glyph_code_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_take; fetch_req_i && fetch_ready_o; endsequence
	sequence s_done; pix_valid_o || glyph_valid_o; endsequence
	property p_start; s_take |-> ##2 (mem_rd_o || pix_valid_o); endproperty
	property p_busy; s_take |=> !fetch_ready_o; endproperty
	property p_rd_pulse; mem_rd_o |=> !mem_rd_o; endproperty
	property p_rd_busy; mem_rd_o |-> !fetch_ready_o; endproperty
	property p_addr_hold; mem_rd_o |=> $stable(mem_addr_o) [*2]; endproperty
	property p_ready_back; s_done |=> fetch_ready_o; endproperty
	property p_done_pulse; s_done |=> !pix_valid_o && !glyph_valid_o; endproperty
	property p_glyph_font; glyph_valid_o |-> glyph_handle_o == {4'h8, glyph_code_o[7]}; endproperty
	a_start: assert property (p_start) else $error("fetch did not start two cycles after acceptance");
	a_busy: assert property (p_busy) else $error("ready stayed high after acceptance");
	a_rd_pulse: assert property (p_rd_pulse) else $error("memory read longer than one cycle");
	a_rd_busy: assert property (p_rd_busy) else $error("ready high during memory read");
	a_addr_hold: assert property (p_addr_hold) else $error("memory address moved while read open");
	a_ready_back: assert property (p_ready_back) else $error("ready not back after result");
	a_done_pulse: assert property (p_done_pulse) else $error("result pulse longer than one cycle");
	a_glyph_font: assert property (p_glyph_font) else $error("glyph font handle wrong for code");
endmodule
bind bmsd_decoder bmsd_decoder_asserts u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .fetch_req_i(fetch_req_i),
	.fetch_ready_o(fetch_ready_o), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .pix_valid_o(pix_valid_o),
	.glyph_valid_o(glyph_valid_o), .glyph_handle_o(glyph_handle_o), .glyph_code_o(glyph_code_o));
`default_nettype wire

// ==== verif/bmsd_decoder_tb.sv ====
// command and texel fetch testbench of the bitmap state decoder
`timescale 1ns/1ps
`default_nettype none
module bmsd_decoder_tb;
	logic        clk_i = 0, reset_n_i = 0, cmd_valid_i = 0, pal_wr_i = 0, pal_rd_i = 0, fetch_req_i = 0, slow = 0;
	logic [31:0] cmd_word_i = '0, pal_wdata_i = '0, pal_rdata_o, pix_argb_o;
	logic [4:0]  cmd_handle_i = '0, fetch_handle_i = '0, glyph_handle_o;
	logic [8:0]  fetch_x_i = '0, fetch_y_i = '0, pix_width_o, pix_height_o;
	logic [7:0]  pal_addr_i = '0, glyph_code_o;
	logic [19:0] mem_addr_o;
	logic [15:0] mem_data_i;
	logic [3:0]  glyph_fg_o;
	logic [2:0]  glyph_row_o, glyph_col_o, glyph_bg_o;
	logic        fetch_ready_o, mem_rd_o, mem_valid_i, pix_valid_o, pix_bilinear_o, glyph_valid_o, glyph_cursor_o;
	int          err_count = 0, checks = 0, rd_cnt = 0, n, rd_base;
	bmsd_decoder i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid_i), .cmd_word_i(cmd_word_i),
		.cmd_handle_i(cmd_handle_i), .pal_addr_i(pal_addr_i), .pal_wdata_i(pal_wdata_i), .pal_wr_i(pal_wr_i),
		.pal_rd_i(pal_rd_i), .pal_rdata_o(pal_rdata_o), .fetch_req_i(fetch_req_i), .fetch_handle_i(fetch_handle_i),
		.fetch_x_i(fetch_x_i), .fetch_y_i(fetch_y_i), .fetch_ready_o(fetch_ready_o), .mem_addr_o(mem_addr_o),
		.mem_rd_o(mem_rd_o), .mem_valid_i(mem_valid_i), .mem_data_i(mem_data_i), .pix_argb_o(pix_argb_o),
		.pix_valid_o(pix_valid_o), .pix_bilinear_o(pix_bilinear_o), .pix_width_o(pix_width_o),
		.pix_height_o(pix_height_o), .glyph_valid_o(glyph_valid_o), .glyph_code_o(glyph_code_o),
		.glyph_handle_o(glyph_handle_o), .glyph_row_o(glyph_row_o), .glyph_col_o(glyph_col_o),
		.glyph_fg_o(glyph_fg_o), .glyph_bg_o(glyph_bg_o), .glyph_cursor_o(glyph_cursor_o));
	bmsd_mem_model i_mem (.clk_i(clk_i), .slow_i(slow), .rd_i(mem_rd_o), .addr_i(mem_addr_o),
		.valid_o(mem_valid_i), .data_o(mem_data_i));
	// 100 MHz clock and read counter
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) if (mem_rd_o) rd_cnt++;
	function automatic logic [31:0] lay(input logic [4:0] f, input logic [9:0] p, input logic [8:0] h);
		return {8'h07, f, p, h};
	endfunction
	function automatic logic [31:0] sz(input logic f, wx, wy, input logic [8:0] w, h);
		return {8'h08, 3'h0, f, wx, wy, w, h};
	endfunction
	task automatic results;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		checks++;
		if (g !== e)
		begin
			err_count++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cmd(input logic [4:0] h, input logic [31:0] w);
		@(posedge clk_i);
		cmd_valid_i <= 1; cmd_handle_i <= h; cmd_word_i <= w;
		@(posedge clk_i);
		cmd_valid_i <= 0;
	endtask
	// a handle with point sampling, border wrap and an 8x8 drawn size
	task automatic setup(input logic [4:0] h, input logic [19:0] a, input logic [4:0] f, input logic [9:0] p,
		input logic [8:0] ht);
		cmd(h, {8'h01, 4'h0, a});
		cmd(h, lay(f, p, ht));
		cmd(h, sz(0, 0, 0, 8, 8));
	endtask
	// request taken at the first edge since ready idles high; result awaited with a bound
	task automatic fetch(input logic [4:0] h, input logic [8:0] x, y);
		@(posedge clk_i);
		fetch_req_i <= 1; fetch_handle_i <= h; fetch_x_i <= x; fetch_y_i <= y;
		@(posedge clk_i);
		fetch_req_i <= 0;
		for (n = 0; n < 20 && !(pix_valid_o === 1'b1 || glyph_valid_o === 1'b1); n++) @(negedge clk_i);
		if (n == 20)
		begin
			err_count++;
			$display("unexpected fetch timeout expected result seen none");
			results();
		end
	endtask
	task automatic pal(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		pal_wr_i <= wr; pal_rd_i <= !wr; pal_addr_i <= a; pal_wdata_i <= d;
		@(posedge clk_i);
		pal_wr_i <= 0; pal_rd_i <= 0;
		@(negedge clk_i);
		if (!wr) chk("palette", d, pal_rdata_o);
	endtask
	// main sequence
	initial
	begin
		repeat (8) @(posedge clk_i);
		reset_n_i <= 1;
		setup(3, 20'h00100, 5'd7, 10'd16, 9'd4);
		cmd(3, sz(1, 0, 0, 100, 50));
		fetch(3, 2, 1);
		chk("addr", 32'h114, {12'h0, mem_addr_o});
		chk("rgb565", 32'hffb5148c, pix_argb_o);
		chk("size", {13'h0, 1'b1, 9'd100, 9'd50}, {13'h0, pix_bilinear_o, pix_width_o, pix_height_o});
		$display("test layout done");
		slow <= 1;
		cmd(3, sz(0, 1, 0, 9, 8));
		cmd(3, 32'h02ff_ffff);
		fetch(3, 9, 1);
		chk("repeat addr", 32'h112, {12'h0, mem_addr_o});
		chk("size2", {14'h0, 9'd9, 9'd8}, {13'h0, pix_bilinear_o, pix_width_o, pix_height_o});
		rd_base = rd_cnt;
		fetch(3, 2, 9);
		chk("border", 32'h0, pix_argb_o);
		chk("reads", rd_base, rd_cnt);
		$display("test wrap done");
		setup(5, 20'h00400, 5'd1, 10'd2, 9'd2);
		cmd(5, {8'h01, 4'h0, 20'h00500});
		fetch(5, 5, 1);
		chk("mono addr", 32'h502, {12'h0, mem_addr_o});
		chk("mono", 32'hffffffff, pix_argb_o);
		pal(1, 8'ha4, 32'h44332211);
		pal(0, 8'ha4, 32'h44332211);
		setup(6, 20'h00400, 5'd8, 10'd8, 9'd2);
		fetch(6, 1, 0);
		chk("indexed", 32'h11223344, pix_argb_o);
		setup(31, 20'h00200, 5'd11, 10'd256, 9'd1);
		fetch(31, 3, 167);
		chk("plot on", 32'hffffffff, pix_argb_o);
		fetch(31, 3, 166);
		chk("plot off", 32'h0, pix_argb_o);
		setup(17, 20'h00300, 5'd9, 10'd4, 9'd4);
		fetch(17, 13, 10);
		chk("glyph", 32'h455a0, {8'h0, 5'h0, glyph_handle_o, glyph_row_o, glyph_col_o, glyph_code_o});
		cmd(17, lay(5'd10, 10'd4, 9'd4));
		fetch(17, 8, 0);
		chk("attr", 32'ha6a7, {16'h0, glyph_cursor_o, glyph_bg_o, glyph_fg_o, glyph_code_o});
		$display("test formats done");
		results();
	end
endmodule
`default_nettype wire
